// ### rtl/dir_router.sv
// Top of the discrete input router with its Avalon-MM register slave
`timescale 1ns/1ps
`default_nettype none
module dir_router
    import dir_pkg::*;
(
    // Clock, reset, enable
    input  wire logic                  i_core_clk,
    input  wire logic                  i_rst_b,
    input  wire logic                  i_clk_en,
    // Discrete inputs and drive state
    input  wire logic [DIR_NUM_IN-1:0] i_di,
    input  wire logic                  i_drive_running,
    // Avalon-MM slave
    input  wire logic [7:0]            i_avs_address,
    input  wire logic                  i_avs_read,
    input  wire logic                  i_avs_write,
    input  wire logic [31:0]           i_avs_writedata,
    input  wire logic [3:0]            i_avs_byteenable,
    output logic      [31:0]           o_avs_readdata,
    output logic                       o_avs_waitrequest,
    // Decoded sequence requests and routed command words two and three
    output dir_cmd_t                   o_cmd,
    output logic      [DIR_WORD_W-1:0] o_word_two,
    output logic      [DIR_WORD_W-1:0] o_word_three
);
    typedef enum logic [1:0] {
        DIR_BUS_IDLE = 2'b01,
        DIR_BUS_ACK  = 2'b10
    } dir_bus_t;

    // Places each routed input into one of the three words
    function automatic logic [DIR_WORD_W-1:0] dir_route_word(
        input logic [1:0]            w,
        input logic [DIR_NUM_IN-1:0] di,
        input dir_route_t [7:1]      rt,
        input logic                  set_mode
    );
        logic [DIR_WORD_W-1:0] acc;
        acc = '0;
        for (int n = 1; n < DIR_NUM_IN; n++) begin
            if (n == 7 && set_mode) begin
                if (w == DIR_WORD_ONE) begin
                    acc[DIR_B_SPEED2] = acc[DIR_B_SPEED2] | di[7];
                end
            end else if (rt[n].word == w && w != DIR_WORD_NONE) begin
                acc[rt[n].pos] = acc[rt[n].pos] | di[n];
            end
        end
        // Safety permit cannot be masked by a routed input
        if (w == DIR_WORD_ONE) begin
            acc[DIR_B_SAFETY] = di[0];
        end
        return acc;
    endfunction : dir_route_word

    logic [DIR_NUM_IN-1:0] di_s;
    dir_route_t [7:1]      route_r;
    dir_route_t [7:1]      route_nxt;
    dir_ctrl_t             ctrl_r;
    dir_ctrl_t             ctrl_nxt;
    logic [DIR_WORD_W-1:0] word1_r;
    logic [DIR_WORD_W-1:0] word1_nxt;
    logic [DIR_WORD_W-1:0] word2_r;
    logic [DIR_WORD_W-1:0] word2_nxt;
    logic [DIR_WORD_W-1:0] word3_r;
    logic [DIR_WORD_W-1:0] word3_nxt;
    dir_cmd_t              cmd_r;
    dir_cmd_t              cmd_nxt;
    dir_bus_t              bus_r;
    dir_bus_t              bus_nxt;
    logic [31:0]           rdata_r;
    logic [31:0]           rdata_nxt;
    logic                  req;
    logic                  wr_take;
    logic [2:0]            route_idx;
    logic                  route_hit;

    // Inputs from plant contacts
    dir_sync u_sync (
        .i_core_clk (i_core_clk),
        .i_rst_b    (i_rst_b),
        .i_clk_en   (i_clk_en),
        .i_async    (i_di),
        .o_sync     (di_s)
    );

    dir_decode u_decode (
        .i_word    (word1_r),
        .i_ctrl    (ctrl_r),
        .i_running (i_drive_running),
        .o_cmd     (cmd_nxt)
    );

    // Bus handshake: one wait cycle, answer on the second edge
    assign req               = i_avs_read | i_avs_write;
    assign o_avs_waitrequest = req & ~(bus_r == DIR_BUS_ACK && i_clk_en);
    assign wr_take           = i_avs_write && bus_r == DIR_BUS_ACK;
    assign route_idx         = i_avs_address[4:2];
    assign route_hit         = i_avs_address >= DIR_OFS_ROUTE1
                               && i_avs_address <= DIR_OFS_ROUTE7
                               && i_avs_address[1:0] == 2'h0;

    always_comb begin
        case (bus_r)
            DIR_BUS_IDLE: bus_nxt = req ? DIR_BUS_ACK : DIR_BUS_IDLE;
            DIR_BUS_ACK:  bus_nxt = DIR_BUS_IDLE;
            default:      bus_nxt = DIR_BUS_IDLE;
        endcase
    end

    // Read data is sampled when the request is first seen
    always_comb begin
        rdata_nxt = rdata_r;
        if (bus_r == DIR_BUS_IDLE && i_avs_read) begin
            rdata_nxt = 32'h0000_0000;
            if (route_hit) begin
                rdata_nxt[5:0] = route_r[route_idx];
            end else begin
                case (i_avs_address)
                    DIR_OFS_INPUTS: rdata_nxt[7:0]  = di_s;
                    DIR_OFS_CTRL:   rdata_nxt[3:0]  = ctrl_r;
                    DIR_OFS_WORD1:  rdata_nxt[15:0] = word1_r;
                    DIR_OFS_WORD2:  rdata_nxt[15:0] = word2_r;
                    DIR_OFS_WORD3:  rdata_nxt[15:0] = word3_r;
                    DIR_OFS_STATUS: rdata_nxt[16:0] = cmd_r;
                    default:        rdata_nxt       = 32'h0000_0000;
                endcase
            end
        end
    end

    // Configuration writes; only the low byte lane carries fields
    always_comb begin
        route_nxt = route_r;
        ctrl_nxt  = ctrl_r;
        if (wr_take && i_avs_byteenable[0]) begin
            if (route_hit) begin
                route_nxt[route_idx] = i_avs_writedata[5:0];
            end else if (i_avs_address == DIR_OFS_CTRL) begin
                ctrl_nxt = i_avs_writedata[3:0];
            end
        end
    end

    // Command words rebuilt every enabled cycle
    always_comb begin
        word1_nxt = dir_route_word(DIR_WORD_ONE, di_s, route_r,
                                   ctrl_r.set_mode);
        word2_nxt = dir_route_word(DIR_WORD_TWO, di_s, route_r,
                                   ctrl_r.set_mode);
        word3_nxt = dir_route_word(DIR_WORD_THREE, di_s, route_r,
                                   ctrl_r.set_mode);
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_rst_b) begin
            bus_r   <= DIR_BUS_IDLE;
            rdata_r <= 32'h0000_0000;
            route_r <= {7{DIR_ROUTE_RST}};
            ctrl_r  <= DIR_CTRL_RST;
            word1_r <= 16'h0000;
            word2_r <= 16'h0000;
            word3_r <= 16'h0000;
            cmd_r   <= '0;
        end else if (i_clk_en) begin
            bus_r   <= bus_nxt;
            rdata_r <= rdata_nxt;
            route_r <= route_nxt;
            ctrl_r  <= ctrl_nxt;
            word1_r <= word1_nxt;
            word2_r <= word2_nxt;
            word3_r <= word3_nxt;
            cmd_r   <= cmd_nxt;
        end
    end

    assign o_avs_readdata = rdata_r;
    assign o_cmd          = cmd_r;
    assign o_word_two     = word2_r;
    assign o_word_three   = word3_r;

    // Checks
    default clocking dir_cb @(posedge i_core_clk);
    endclocking
    default disable iff (!i_rst_b);

    sequence dir_il_loss_s;
        i_clk_en && i_drive_running && !word1_r[DIR_B_INTERLOCK];
    endsequence

    sequence dir_rd_take_s;
        i_clk_en && bus_r == DIR_BUS_IDLE && i_avs_read;
    endsequence

    safety_fixed_route_a: assert property (
        i_clk_en |=> word1_r[DIR_B_SAFETY] == $past(di_s[0]))
        else $error("safety bit does not follow input zero");

    speed_override_a: assert property (
        (i_clk_en && ctrl_r.set_mode && di_s[7]) |=> word1_r[DIR_B_SPEED2])
        else $error("input seven not forced to second speed");

    route_place_a: assert property (
        (i_clk_en && !ctrl_r.set_mode && route_r[7].word == DIR_WORD_TWO
            && di_s[7])
        |=> word2_r[$past(route_r[7].pos)])
        else $error("routed input missing from selected word");

    unassigned_zero_a: assert property (
        (i_clk_en && route_r == {7{DIR_ROUTE_RST}} && !ctrl_r.set_mode)
        |=> word2_r == 16'h0000 && word3_r == 16'h0000
            && (word1_r & 16'hBFFF) == 16'h0000)
        else $error("unassigned bits not zero");

    interlock_coast_a: assert property (
        dir_il_loss_s |=> o_cmd.coast_stop)
        else $error("interlock loss gave no coast stop");

    safety_trip_a: assert property (
        (i_clk_en && i_drive_running && !word1_r[DIR_B_SAFETY])
        |=> o_cmd.safety_trip)
        else $error("safety loss not flagged");

    run_stop_kind_a: assert property (
        (i_clk_en && i_drive_running && word1_r[DIR_B_INTERLOCK]
            && !word1_r[DIR_B_RUN])
        |=> (o_cmd.decel_stop == $past(ctrl_r.decel_sel))
            && (o_cmd.coast_stop == !$past(ctrl_r.decel_sel)))
        else $error("run removal gave wrong stop kind");

    tension_slave_a: assert property (
        i_clk_en |=> !(o_cmd.tension_select && o_cmd.slave_torque)
            && (o_cmd.slave_torque
                == ($past(word1_r[DIR_B_TENSION]) && $past(ctrl_r.mech_couple))))
        else $error("control selection decode wrong");

    jog_guard_a: assert property (
        (i_clk_en && word1_r[DIR_B_RUN]) |=> !o_cmd.jog_fwd && !o_cmd.jog_rev)
        else $error("jog honoured while run requested");

    speed_code_a: assert property (
        (i_clk_en && word1_r[7:6] == 2'h0) |=> o_cmd.speed_sel == DIR_SPD_FIRST)
        else $error("first speed not chosen");

    excite_guard_a: assert property (
        (i_clk_en && word1_r[DIR_B_EXCITE] && !word1_r[DIR_B_RUN])
        |=> o_cmd.excite_cmd)
        else $error("excitation not requested");

    wind_dir_a: assert property (
        i_clk_en |=> o_cmd.reverse_wind == $past(word1_r[DIR_B_REVERSE])
            && o_cmd.brake_release == $past(word1_r[DIR_B_BRAKE]))
        else $error("winding or brake bit decode wrong");

    bus_answer_a: assert property (
        (req && bus_r == DIR_BUS_IDLE && i_clk_en) |-> o_avs_waitrequest
            ##1 (!i_clk_en || !o_avs_waitrequest))
        else $error("bus answer timing wrong");

    // Read data is captured from the word as it stood when taken
    word_read_a: assert property (
        (dir_rd_take_s ##0 i_avs_address == DIR_OFS_WORD1)
        |=> o_avs_readdata == {16'h0000, $past(word1_r)})
        else $error("command word read data wrong");

    ctrl_write_a: assert property (
        (i_clk_en && wr_take && i_avs_byteenable[0]
            && i_avs_address == DIR_OFS_CTRL)
        |=> ctrl_r == $past(i_avs_writedata[3:0]))
        else $error("control write did not land");

    permit_pass_a: assert property (
        i_clk_en |=> o_cmd.interlock_permit == $past(word1_r[DIR_B_INTERLOCK])
            && o_cmd.safety_switch_ok == $past(word1_r[DIR_B_SAFETY])
            && o_cmd.run_request == $past(word1_r[DIR_B_RUN]))
        else $error("permit or run bit decode wrong");

    stop_idle_a: assert property (
        (i_clk_en && !i_drive_running)
        |=> !o_cmd.coast_stop && !o_cmd.decel_stop && !o_cmd.safety_trip)
        else $error("stop request while drive idle");

    jog_conflict_a: assert property (
        (i_clk_en && word1_r[DIR_B_RUN]
            && (word1_r[DIR_B_JOG_FWD] || word1_r[DIR_B_JOG_REV]))
        |=> o_cmd.jog_conflict)
        else $error("run with jog not flagged");

    jog_pass_a: assert property (
        (i_clk_en && !word1_r[DIR_B_RUN])
        |=> o_cmd.jog_fwd == $past(word1_r[DIR_B_JOG_FWD])
            && o_cmd.jog_rev == $past(word1_r[DIR_B_JOG_REV]))
        else $error("jog request not passed");

    speed_upper_a: assert property (
        (i_clk_en && word1_r[DIR_B_SPEED3])
        |=> o_cmd.speed_sel == DIR_SPD_THIRD)
        else $error("third speed not chosen");

    speed_second_a: assert property (
        (i_clk_en && word1_r[7:6] == 2'h1)
        |=> o_cmd.speed_sel == DIR_SPD_SECOND)
        else $error("second speed not chosen");

    excite_run_a: assert property (
        (i_clk_en && word1_r[DIR_B_RUN]) |=> !o_cmd.excite_cmd)
        else $error("excitation honoured while run requested");

    torque_dir_a: assert property (
        i_clk_en |=> o_cmd.torque_dir
            == ($past(word1_r[DIR_B_REVERSE]) && $past(ctrl_r.torque_ctrl)))
        else $error("torque direction decode wrong");

endmodule : dir_router
`default_nettype wire

// ### rtl/dir_pkg.sv
// Constants, types and field layout for the discrete input router
package dir_pkg;

    localparam int           DIR_NUM_IN      = 8;
    localparam int           DIR_WORD_W      = 16;
    localparam logic [1:0]   DIR_WORD_NONE   = 2'h0;
    localparam logic [1:0]   DIR_WORD_ONE    = 2'h1;
    localparam logic [1:0]   DIR_WORD_TWO    = 2'h2;
    localparam logic [1:0]   DIR_WORD_THREE  = 2'h3;

    // Command word one bit positions
    localparam int           DIR_B_INTERLOCK = 15;
    localparam int           DIR_B_SAFETY    = 14;
    localparam int           DIR_B_RUN       = 13;
    localparam int           DIR_B_TENSION   = 10;
    localparam int           DIR_B_JOG_FWD   = 9;
    localparam int           DIR_B_JOG_REV   = 8;
    localparam int           DIR_B_SPEED3    = 7;
    localparam int           DIR_B_SPEED2    = 6;
    localparam int           DIR_B_BRAKE     = 5;
    localparam int           DIR_B_EXCITE    = 4;
    localparam int           DIR_B_REVERSE   = 0;

    // Speed selection codes
    localparam logic [1:0]   DIR_SPD_FIRST   = 2'h0;
    localparam logic [1:0]   DIR_SPD_SECOND  = 2'h1;
    localparam logic [1:0]   DIR_SPD_THIRD   = 2'h2;

    // Register byte offsets
    localparam logic [7:0]   DIR_OFS_INPUTS  = 8'h00;
    localparam logic [7:0]   DIR_OFS_ROUTE1  = 8'h04;
    localparam logic [7:0]   DIR_OFS_ROUTE7  = 8'h1C;
    localparam logic [7:0]   DIR_OFS_CTRL    = 8'h20;
    localparam logic [7:0]   DIR_OFS_WORD1   = 8'h24;
    localparam logic [7:0]   DIR_OFS_WORD2   = 8'h28;
    localparam logic [7:0]   DIR_OFS_WORD3   = 8'h2C;
    localparam logic [7:0]   DIR_OFS_STATUS  = 8'h30;

    typedef struct packed {
        logic [1:0] word;
        logic [3:0] pos;
    } dir_route_t;

    typedef struct packed {
        logic torque_ctrl;
        logic mech_couple;
        logic decel_sel;
        logic set_mode;
    } dir_ctrl_t;

    typedef struct packed {
        logic       interlock_permit;
        logic       safety_switch_ok;
        logic       run_request;
        logic       tension_select;
        logic       slave_torque;
        logic       jog_fwd;
        logic       jog_rev;
        logic [1:0] speed_sel;
        logic       brake_release;
        logic       excite_cmd;
        logic       reverse_wind;
        logic       torque_dir;
        logic       coast_stop;
        logic       decel_stop;
        logic       safety_trip;
        logic       jog_conflict;
    } dir_cmd_t;

    localparam dir_route_t   DIR_ROUTE_RST   = '{word: 2'h0, pos: 4'h0};
    localparam dir_ctrl_t    DIR_CTRL_RST    = '0;

endpackage : dir_pkg

// ### rtl/dir_sync.sv
// Two-stage synchroniser for the discrete inputs
`timescale 1ns/1ps
`default_nettype none
module dir_sync
    import dir_pkg::*;
(
    // Clock and reset
    input  wire logic                  i_core_clk,
    input  wire logic                  i_rst_b,
    input  wire logic                  i_clk_en,
    // Data
    input  wire logic [DIR_NUM_IN-1:0] i_async,
    output logic      [DIR_NUM_IN-1:0] o_sync
);
    logic [DIR_NUM_IN-1:0] s1_r;
    logic [DIR_NUM_IN-1:0] s2_r;

    // First stage feeds only the second
    always_ff @(posedge i_core_clk) begin
        if (!i_rst_b) begin
            s1_r <= '0;
            s2_r <= '0;
        end else if (i_clk_en) begin
            s1_r <= i_async;
            s2_r <= s1_r;
        end
    end

    assign o_sync = s2_r;

    sync_delay_a: assert property (
        @(posedge i_core_clk) disable iff (!i_rst_b)
        ($past(i_rst_b) && $past(i_rst_b, 2)
            && $past(i_clk_en) && $past(i_clk_en, 2))
        |-> o_sync == $past(i_async, 2))
        else $error("synchroniser delay is not two cycles");

endmodule : dir_sync
`default_nettype wire

// ### rtl/dir_decode.sv
// Decoder from command word one to drive sequence requests
`timescale 1ns/1ps
`default_nettype none
module dir_decode
    import dir_pkg::*;
(
    // Inputs
    input  wire logic [DIR_WORD_W-1:0] i_word,
    input  var  dir_ctrl_t             i_ctrl,
    input  wire logic                  i_running,
    // Result
    output dir_cmd_t                   o_cmd
);
    always_comb begin
        o_cmd                  = '0;
        o_cmd.interlock_permit = i_word[DIR_B_INTERLOCK];
        o_cmd.safety_switch_ok = i_word[DIR_B_SAFETY];
        o_cmd.run_request      = i_word[DIR_B_RUN];
        o_cmd.tension_select   = i_word[DIR_B_TENSION] & i_ctrl.torque_ctrl
                                 & ~i_ctrl.mech_couple;
        o_cmd.slave_torque     = i_word[DIR_B_TENSION] & i_ctrl.mech_couple;
        // Jog only honoured while run is low
        o_cmd.jog_fwd          = i_word[DIR_B_JOG_FWD] & ~i_word[DIR_B_RUN];
        o_cmd.jog_rev          = i_word[DIR_B_JOG_REV] & ~i_word[DIR_B_RUN];
        o_cmd.jog_conflict     = i_word[DIR_B_RUN] & (i_word[DIR_B_JOG_FWD]
                                 | i_word[DIR_B_JOG_REV]);
        // Third speed wins if both selects are set
        if (i_word[DIR_B_SPEED3]) begin
            o_cmd.speed_sel = DIR_SPD_THIRD;
        end else if (i_word[DIR_B_SPEED2]) begin
            o_cmd.speed_sel = DIR_SPD_SECOND;
        end else begin
            o_cmd.speed_sel = DIR_SPD_FIRST;
        end
        o_cmd.brake_release    = i_word[DIR_B_BRAKE];
        o_cmd.excite_cmd       = i_word[DIR_B_EXCITE]
                                 & ~i_word[DIR_B_RUN];
        o_cmd.reverse_wind     = i_word[DIR_B_REVERSE];
        o_cmd.torque_dir       = i_word[DIR_B_REVERSE]
                                 & i_ctrl.torque_ctrl;
        // Stop requests only matter once the drive runs
        o_cmd.coast_stop       = i_running & (~i_word[DIR_B_INTERLOCK]
                                 | (~i_word[DIR_B_RUN]
                                 & ~i_ctrl.decel_sel));
        o_cmd.decel_stop       = i_running & i_word[DIR_B_INTERLOCK]
                                 & ~i_word[DIR_B_RUN]
                                 & i_ctrl.decel_sel;
        o_cmd.safety_trip      = i_running & ~i_word[DIR_B_SAFETY];
    end

endmodule : dir_decode
`default_nettype wire

// ### test/dir_plant.sv
// Plant contact model that drives the discrete inputs of the router
`timescale 1ns/1ps
`default_nettype none
module dir_plant
    import dir_pkg::*;
(
    // Clock
    input  wire logic                  i_core_clk,
    // Wanted contact levels and contacts seen by the router
    input  wire logic [DIR_NUM_IN-1:0] i_want,
    output logic      [DIR_NUM_IN-1:0] o_di
);
    // Contacts move just after an edge, as real relays settle between edges
    initial o_di = '0;
    always @(posedge i_core_clk) begin
        o_di <= i_want;
    end
endmodule : dir_plant
`default_nettype wire

// ### test/tb_dir_router.sv
// Self-checking bench for the discrete input router
`timescale 1ns/1ps
`default_nettype none
module tb_dir_router import dir_pkg::*;;
    logic                  clk;
    logic                  rst_b;
    logic                  clk_en;
    logic [DIR_NUM_IN-1:0] want;
    logic [DIR_NUM_IN-1:0] di;
    logic                  running;
    logic [7:0]            addr;
    logic                  rd;
    logic                  wr;
    logic [31:0]           wdata;
    logic [3:0]            be;
    logic [31:0]           rdata;
    logic                  waitreq;
    dir_cmd_t              cmd;
    logic [DIR_WORD_W-1:0] word_two;
    logic [DIR_WORD_W-1:0] word_three;
    int                    failures;
    int                    num_checks;

    dir_router dir_router_inst (.i_core_clk(clk), .i_rst_b(rst_b),
        .i_clk_en(clk_en), .i_di(di), .i_drive_running(running),
        .i_avs_address(addr), .i_avs_read(rd), .i_avs_write(wr),
        .i_avs_writedata(wdata), .i_avs_byteenable(be),
        .o_avs_readdata(rdata), .o_avs_waitrequest(waitreq), .o_cmd(cmd),
        .o_word_two(word_two), .o_word_three(word_three));
    dir_plant dir_plant_inst (.i_core_clk(clk), .i_want(want), .o_di(di));

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    task automatic end_sim;
        if (failures == 0 && num_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : end_sim

    task automatic check(input string name, input logic [31:0] seen,
                         input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            failures++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic chk1(input string name, input logic seen, input logic exp);
        check(name, {31'h0, seen}, {31'h0, exp});
    endtask : chk1

    // Request held until waitrequest is sampled low at a rising edge
    task automatic bus(input logic is_wr, input logic [7:0] a,
                       input logic [31:0] d, input logic [3:0] b,
                       output logic [31:0] q);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        be    <= b;
        rd    <= !is_wr;
        wr    <= is_wr;
        // Only the watchdog ends a wait that never finishes
        do begin
            @(posedge clk);
        end while (waitreq !== 1'b0);
        q = rdata;
        rd <= 1'b0;
        wr <= 1'b0;
    endtask : bus

    task automatic wr32(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, 4'hF, q);
    endtask : wr32

    task automatic rd_chk(input string name, input logic [7:0] a,
                          input logic [31:0] exp);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, 4'hF, q);
        check(name, q, exp);
    endtask : rd_chk

    task automatic route(input int n, input logic [1:0] w,
                         input logic [3:0] p);
        wr32(8'(4 * n), {26'h0, w, p});
    endtask : route

    task automatic apply(input logic [7:0] v);
        @(posedge clk);
        want <= v;
        repeat (6) @(posedge clk);
    endtask : apply

    task automatic t_reset;
        logic [31:0] q;
        rd_chk("inputs", DIR_OFS_INPUTS, 32'h0);
        rd_chk("word1", DIR_OFS_WORD1, 32'h0);
        rd_chk("word3", DIR_OFS_WORD3, 32'h0);
        rd_chk("cmd", DIR_OFS_STATUS, 32'h0);
        rd_chk("route7", DIR_OFS_ROUTE7, 32'h0);
        wr32(DIR_OFS_WORD1, 32'hFFFF);
        rd_chk("word1 ro", DIR_OFS_WORD1, 32'h0);
        bus(1'b1, DIR_OFS_CTRL, 32'hF, 4'hE, q);
        rd_chk("ctrl lane", DIR_OFS_CTRL, 32'h0);
        wr32(8'h40, 32'hF);
        rd_chk("unmapped", 8'h40, 32'h0);
    endtask : t_reset

    // Safety contact reaches the command only after both sync stages
    task automatic t_fixed;
        @(posedge clk);
        want <= 8'h01;
        repeat (5) @(posedge clk);
        chk1("early", cmd.safety_switch_ok, 1'b0);
        @(posedge clk);
        chk1("safety", cmd.safety_switch_ok, 1'b1);
        rd_chk("inputs", DIR_OFS_INPUTS, 32'h1);
        rd_chk("word1", DIR_OFS_WORD1, 32'h4000);
        apply(8'h00);
    endtask : t_fixed

    task automatic t_route;
        int p;
        logic [31:0] e;
        for (int n = 1; n < 8; n++) begin
            for (int w = 1; w < 4; w++) begin
                p = (2 * n + 5 * w) % 16;
                e = 32'h1 << p;
                route(n, 2'(w), 4'(p));
                apply(8'(1 << n));
                rd_chk("word1", DIR_OFS_WORD1, (w == 1) ? e : 0);
                check("word2", word_two, (w == 2) ? e : 0);
                check("word3", word_three, (w == 3) ? e : 0);
                route(n, 2'h0, 4'(p));
                repeat (3) @(posedge clk);
                check("none", {word_two, word_three}, 32'h0);
            end
            rd_chk("word1 none", DIR_OFS_WORD1, 32'h0);
            apply(8'h00);
        end
    endtask : t_route

    task automatic t_setmode;
        route(7, 2'h2, 4'h3);
        rd_chk("route7", DIR_OFS_ROUTE7, 32'h23);
        wr32(DIR_OFS_CTRL, 32'h1);
        apply(8'h80);
        rd_chk("word1", DIR_OFS_WORD1, 32'h0040);
        check("word2", word_two, 32'h0);
        check("speed", 32'(cmd.speed_sel), 32'(DIR_SPD_SECOND));
        wr32(DIR_OFS_CTRL, 32'h0);
        repeat (3) @(posedge clk);
        check("word2 back", word_two, 32'h0008);
        apply(8'h00);
        route(7, 2'h0, 4'h0);
    endtask : t_setmode

    task automatic t_decode;
        logic [3:0] pa [1:7];
        pa = '{4'hF, 4'hD, 4'hA, 4'h9, 4'h8, 4'h5, 4'h0};
        for (int n = 1; n < 8; n++) route(n, 2'h1, pa[n]);
        wr32(DIR_OFS_CTRL, 32'h8);
        apply(8'hCB);
        chk1("interlock", cmd.interlock_permit, 1'b1);
        chk1("tension", cmd.tension_select, 1'b1);
        chk1("brake", cmd.brake_release, 1'b1);
        chk1("reverse", cmd.reverse_wind, 1'b1);
        chk1("tdir", cmd.torque_dir, 1'b1);
        wr32(DIR_OFS_CTRL, 32'hC);
        repeat (3) @(posedge clk);
        chk1("slave", cmd.slave_torque, 1'b1);
        chk1("tension cpl", cmd.tension_select, 1'b0);
        wr32(DIR_OFS_CTRL, 32'h0);
        repeat (3) @(posedge clk);
        chk1("tdir spd", cmd.torque_dir, 1'b0);
        apply(8'h10);
        chk1("jog fwd", cmd.jog_fwd, 1'b1);
        apply(8'h20);
        chk1("jog rev", cmd.jog_rev, 1'b1);
        apply(8'h24);
        chk1("jog gated", cmd.jog_rev, 1'b0);
        chk1("conflict", cmd.jog_conflict, 1'b1);
        running <= 1'b1;
        apply(8'h07);
        chk1("no stop", cmd.coast_stop | cmd.decel_stop, 1'b0);
        chk1("run", cmd.run_request, 1'b1);
        apply(8'h05);
        chk1("il coast", cmd.coast_stop, 1'b1);
        apply(8'h07);
        wr32(DIR_OFS_CTRL, 32'h2);
        apply(8'h03);
        chk1("decel", cmd.decel_stop, 1'b1);
        chk1("no coast", cmd.coast_stop, 1'b0);
        wr32(DIR_OFS_CTRL, 32'h0);
        repeat (3) @(posedge clk);
        chk1("run coast", cmd.coast_stop, 1'b1);
        apply(8'h06);
        chk1("trip", cmd.safety_trip, 1'b1);
        running <= 1'b0;
        route(6, 2'h1, 4'h7);
        route(7, 2'h1, 4'h4);
        apply(8'hC0);
        check("speed3", 32'(cmd.speed_sel), 32'(DIR_SPD_THIRD));
        chk1("excite", cmd.excite_cmd, 1'b1);
        apply(8'hC4);
        chk1("excite run", cmd.excite_cmd, 1'b0);
        apply(8'h00);
        check("speed1", 32'(cmd.speed_sel), 32'(DIR_SPD_FIRST));
    endtask : t_decode

    // Enable low must hold every stage, so the contact stays unseen
    task automatic t_freeze;
        @(posedge clk);
        clk_en <= 1'b0;
        want   <= 8'h01;
        repeat (6) @(posedge clk);
        chk1("frozen", cmd.safety_switch_ok, 1'b0);
        clk_en <= 1'b1;
        repeat (6) @(posedge clk);
        chk1("thawed", cmd.safety_switch_ok, 1'b1);
        apply(8'h00);
    endtask : t_freeze

    initial begin
        failures   = 0;
        num_checks = 0;
        rst_b      = 1'b0;
        clk_en     = 1'b1;
        want       = '0;
        running    = 1'b0;
        addr       = 8'h00;
        rd         = 1'b0;
        wr         = 1'b0;
        wdata      = 32'h0;
        be         = 4'hF;
        repeat (6) @(posedge clk);
        rst_b <= 1'b1;
        t_reset();
        t_fixed();
        t_route();
        t_setmode();
        t_decode();
        t_freeze();
        end_sim();
    end

    // A hung bus or stuck wait ends the run well past the expected length
    initial begin
        repeat (40000) @(posedge clk);
        failures++;
        end_sim();
    end
endmodule : tb_dir_router
`default_nettype wire
